// ===== acc_defs.vh
// register map, field positions and codes for the accelerometer output register bank
// How it works
// - temperature code readable at 26h
// - code zero means 25 degrees ambient
// - status bit seven shows fifo level reached
// - status wake flag set by wakeup event
// - status inactivity flag set by sleep event
// - status second-tap flag set by double tap
// - status lone-tap flag set by single tap
// - status orientation flag set by position change
// - status free-fall flag set by free fall
// - status new sample flag on fresh data
// - axis words sixteen bit, low byte even
// - x bytes at 28h/29h, low bits zero
// - y bytes at 2Ah/2Bh, read only
// - z bytes at 2Ch/2Dh, read only
// - high-rate mode zeroes low byte bits 3:2
// - low-power mode zeroes low byte bits 5:2
// - watermark threshold read/write at 2Eh
// - fifo source repeats watermark flag at 2Fh
// - overrun only when full and overwritten
// - nine bit unread count, msb in 2Fh
// - fifo takes sample on new-sample strobe
// - continuous mode overwrites oldest when full
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

`define ACC_ADDR_TEMPERATURE_OUT   8'h26
`define ACC_ADDR_EVENT_STATUS      8'h27
`define ACC_ADDR_ACCEL_X_LOW       8'h28
`define ACC_ADDR_ACCEL_X_HIGH      8'h29
`define ACC_ADDR_ACCEL_Y_LOW       8'h2a
`define ACC_ADDR_ACCEL_Y_HIGH      8'h2b
`define ACC_ADDR_ACCEL_Z_LOW       8'h2c
`define ACC_ADDR_ACCEL_Z_HIGH      8'h2d
`define ACC_ADDR_FIFO_WATERMARK    8'h2e
`define ACC_ADDR_FIFO_FILL_STATUS  8'h2f
`define ACC_ADDR_FIFO_UNREAD_LOW   8'h30

`define ACC_RST_WATERMARK          8'h00
`define ACC_RST_BYTE               8'h00

`define ACC_ST_LEVEL               7
`define ACC_ST_WAKE                6
`define ACC_ST_SLEEP               5
`define ACC_ST_DOUBLE_TAP          4
`define ACC_ST_SINGLE_TAP          3
`define ACC_ST_ORIENT              2
`define ACC_ST_FREE_FALL           1
`define ACC_ST_NEW_SAMPLE          0

`define ACC_SRC_LEVEL              7
`define ACC_SRC_OVERRUN            6
`define ACC_SRC_COUNT_MSB          5

`define ACC_FIFO_MODE_SELECT_BYPASS           3'h0
`define ACC_FIFO_MODE_SELECT_STOP_FULL        3'h1
`define ACC_FIFO_MODE_SELECT_CONT_TO_FIFO     3'h3
`define ACC_FIFO_MODE_SELECT_BYPASS_TO_CONT   3'h4
`define ACC_FIFO_MODE_SELECT_CONTINUOUS       3'h6

`define ACC_FIFO_FULL_COUNT        9'h100

`endif

// ===== acc_axis_latch.v
// one axis output word: captured per sample, low byte masked by power mode
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_axis_latch #(
	parameter WIDTH = 16
) (
	input  wire             sys_clk,
	input  wire             rst,
	input  wire             sample_strobe,
	input  wire [WIDTH-1:0] sample_word,
	input  wire             high_rate_mode,
	input  wire             low_power_mode,
	output reg  [7:0]       low_byte,
	output reg  [7:0]       high_byte
);
	// mask computed on the incoming sample so both bytes always pair up
	reg [7:0] next_low;

	always @* begin
		next_low = sample_word[7:0];
		next_low[1:0] = 2'h0;
		if (high_rate_mode) begin
			next_low[3:2] = 2'h0;
		end
		if (low_power_mode) begin
			next_low[5:2] = 4'h0;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			low_byte  <= `ACC_RST_BYTE;
			high_byte <= `ACC_RST_BYTE;
		end else if (sample_strobe) begin
			low_byte  <= next_low;
			high_byte <= sample_word[WIDTH-1:WIDTH-8];
		end
	end
endmodule // acc_axis_latch

// ===== acc_output_status_regs.v
// accelerometer output and status register bank with fifo fill tracking
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_output_status_regs #(
	parameter AXIS_WIDTH = 16,
	parameter COUNT_WIDTH = 9
) (
	input  wire                  sys_clk,
	input  wire                  rst,
	input  wire [7:0]            reg_addr,
	input  wire                  reg_wr,
	input  wire                  reg_rd,
	input  wire [7:0]            reg_wdata,
	output reg  [7:0]            reg_rdata,
	output reg                   reg_rvalid,
	input  wire [7:0]            temp_code,
	input  wire                  sample_strobe,
	input  wire [AXIS_WIDTH-1:0] accel_x,
	input  wire [AXIS_WIDTH-1:0] accel_y,
	input  wire [AXIS_WIDTH-1:0] accel_z,
	input  wire                  high_rate_mode,
	input  wire                  low_power_mode,
	input  wire                  wake_event,
	input  wire                  sleep_event,
	input  wire                  double_tap_event,
	input  wire                  single_tap_event,
	input  wire                  orientation_event,
	input  wire                  free_fall_event,
	input  wire [2:0]            fifo_mode_select,
	input  wire                  fifo_pop,
	output reg                   fifo_level_reached_flag,
	output reg                   fifo_overrun_flag,
	output reg  [COUNT_WIDTH-1:0] unread_count
);
	reg  [7:0]             temperature_out;
	reg  [7:0]             fifo_watermark;
	reg                    wake_event_flag;
	reg                    sleep_flag;
	reg                    double_tap_flag;
	reg                    single_tap_flag;
	reg                    orientation_change_flag;
	reg                    free_fall_flag;
	reg                    new_sample_flag;
	wire [7:0]             x_low;
	wire [7:0]             x_high;
	wire [7:0]             y_low;
	wire [7:0]             y_high;
	wire [7:0]             z_low;
	wire [7:0]             z_high;
	wire                   status_read;
	wire                   fifo_on;
	wire                   overwrite_mode;
	wire                   fifo_full;
	wire                   push;
	wire                   grow;
	wire                   shrink;
	wire                   overwrite;
	wire                   next_level;
	wire [COUNT_WIDTH-1:0] next_count;
	reg  [7:0]             next_rdata;

	acc_axis_latch #(.WIDTH(AXIS_WIDTH)) u_axis_x (
		.sys_clk        (sys_clk),
		.rst            (rst),
		.sample_strobe  (sample_strobe),
		.sample_word    (accel_x),
		.high_rate_mode (high_rate_mode),
		.low_power_mode (low_power_mode),
		.low_byte       (x_low),
		.high_byte      (x_high)
	);
	acc_axis_latch #(.WIDTH(AXIS_WIDTH)) u_axis_y (
		.sys_clk        (sys_clk),
		.rst            (rst),
		.sample_strobe  (sample_strobe),
		.sample_word    (accel_y),
		.high_rate_mode (high_rate_mode),
		.low_power_mode (low_power_mode),
		.low_byte       (y_low),
		.high_byte      (y_high)
	);
	acc_axis_latch #(.WIDTH(AXIS_WIDTH)) u_axis_z (
		.sys_clk        (sys_clk),
		.rst            (rst),
		.sample_strobe  (sample_strobe),
		.sample_word    (accel_z),
		.high_rate_mode (high_rate_mode),
		.low_power_mode (low_power_mode),
		.low_byte       (z_low),
		.high_byte      (z_high)
	);

	// temperature code: zero stands for 25 degrees, one degree per step
	always @(posedge sys_clk) begin
		if (rst) begin
			temperature_out <= `ACC_RST_BYTE;
		end else begin
			temperature_out <= temp_code;
		end
	end

	// only the watermark is writable, every other address drops the write
	always @(posedge sys_clk) begin
		if (rst) begin
			fifo_watermark <= `ACC_RST_WATERMARK;
		end else if (reg_wr && reg_addr == `ACC_ADDR_FIFO_WATERMARK) begin
			fifo_watermark <= reg_wdata;
		end
	end

	// sticky event flags, cleared by reading status; a new event wins
	assign status_read = reg_rd && reg_addr == `ACC_ADDR_EVENT_STATUS;

	always @(posedge sys_clk) begin
		if (rst) begin
			wake_event_flag         <= 1'b0;
			sleep_flag              <= 1'b0;
			double_tap_flag         <= 1'b0;
			single_tap_flag         <= 1'b0;
			orientation_change_flag <= 1'b0;
			free_fall_flag          <= 1'b0;
			new_sample_flag         <= 1'b0;
		end else begin
			wake_event_flag         <= wake_event | (wake_event_flag & ~status_read);
			sleep_flag              <= sleep_event | (sleep_flag & ~status_read);
			double_tap_flag         <= double_tap_event | (double_tap_flag & ~status_read);
			single_tap_flag         <= single_tap_event | (single_tap_flag & ~status_read);
			orientation_change_flag <= orientation_event
				| (orientation_change_flag & ~status_read);
			free_fall_flag          <= free_fall_event | (free_fall_flag & ~status_read);
			new_sample_flag         <= sample_strobe | (new_sample_flag & ~status_read);
		end
	end

	// fifo fill tracking; storage itself lives outside this bank
	assign fifo_on        = fifo_mode_select != `ACC_FIFO_MODE_SELECT_BYPASS;
	assign overwrite_mode = fifo_mode_select == `ACC_FIFO_MODE_SELECT_CONTINUOUS
		|| fifo_mode_select == `ACC_FIFO_MODE_SELECT_CONT_TO_FIFO;
	assign fifo_full      = unread_count == `ACC_FIFO_FULL_COUNT;
	assign push           = sample_strobe && fifo_on;
	// a pop in the same cycle frees a slot, so the sample lands and nothing is lost
	assign grow           = push && (!fifo_full || shrink);
	assign shrink         = fifo_pop && unread_count != {COUNT_WIDTH{1'b0}};
	assign overwrite      = push && fifo_full && !shrink && overwrite_mode;
	assign next_count     = unread_count + {{(COUNT_WIDTH-1){1'b0}}, grow}
		- {{(COUNT_WIDTH-1){1'b0}}, shrink};
	assign next_level     = fifo_on && next_count >= {1'b0, fifo_watermark};

	always @(posedge sys_clk) begin
		if (rst) begin
			unread_count <= {COUNT_WIDTH{1'b0}};
		end else if (!fifo_on) begin
			// bypass empties the fifo
			unread_count <= {COUNT_WIDTH{1'b0}};
		end else begin
			unread_count <= next_count;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			fifo_overrun_flag <= 1'b0;
		end else if (!fifo_on) begin
			fifo_overrun_flag <= 1'b0;
		end else if (overwrite) begin
			fifo_overrun_flag <= 1'b1;
		end else if (shrink) begin
			// drops on any pop, even when a same-cycle push keeps the fifo full
			fifo_overrun_flag <= 1'b0;
		end
	end

	// level compare registered alongside the count it describes
	always @(posedge sys_clk) begin
		if (rst) begin
			fifo_level_reached_flag <= 1'b0;
		end else begin
			fifo_level_reached_flag <= next_level;
		end
	end

	always @* begin
		next_rdata = 8'h00;
		case (reg_addr)
			`ACC_ADDR_TEMPERATURE_OUT: begin
				next_rdata = temperature_out;
			end
			`ACC_ADDR_EVENT_STATUS: begin
				next_rdata[`ACC_ST_LEVEL]      = fifo_level_reached_flag;
				next_rdata[`ACC_ST_WAKE]       = wake_event_flag;
				next_rdata[`ACC_ST_SLEEP]      = sleep_flag;
				next_rdata[`ACC_ST_DOUBLE_TAP] = double_tap_flag;
				next_rdata[`ACC_ST_SINGLE_TAP] = single_tap_flag;
				next_rdata[`ACC_ST_ORIENT]     = orientation_change_flag;
				next_rdata[`ACC_ST_FREE_FALL]  = free_fall_flag;
				next_rdata[`ACC_ST_NEW_SAMPLE] = new_sample_flag;
			end
			`ACC_ADDR_ACCEL_X_LOW: begin
				next_rdata = x_low;
			end
			`ACC_ADDR_ACCEL_X_HIGH: begin
				next_rdata = x_high;
			end
			`ACC_ADDR_ACCEL_Y_LOW: begin
				next_rdata = y_low;
			end
			`ACC_ADDR_ACCEL_Y_HIGH: begin
				next_rdata = y_high;
			end
			`ACC_ADDR_ACCEL_Z_LOW: begin
				next_rdata = z_low;
			end
			`ACC_ADDR_ACCEL_Z_HIGH: begin
				next_rdata = z_high;
			end
			`ACC_ADDR_FIFO_WATERMARK: begin
				next_rdata = fifo_watermark;
			end
			`ACC_ADDR_FIFO_FILL_STATUS: begin
				next_rdata[`ACC_SRC_LEVEL]     = fifo_level_reached_flag;
				next_rdata[`ACC_SRC_OVERRUN]   = fifo_overrun_flag;
				next_rdata[`ACC_SRC_COUNT_MSB] = unread_count[COUNT_WIDTH-1];
			end
			`ACC_ADDR_FIFO_UNREAD_LOW: begin
				next_rdata = unread_count[7:0];
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end
endmodule // acc_output_status_regs

// ===== acc_regs_monitor.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module acc_regs_monitor #(
	parameter COUNT_WIDTH = 9
) (
	input wire                   sys_clk,
	input wire                   rst,
	input wire [7:0]             reg_addr,
	input wire                   reg_rd,
	input wire [7:0]             reg_rdata,
	input wire                   reg_rvalid,
	input wire [7:0]             temp_code,
	input wire                   sample_strobe,
	input wire [2:0]             fifo_mode_select,
	input wire                   fifo_pop,
	input wire                   fifo_overrun_flag,
	input wire [COUNT_WIDTH-1:0] unread_count
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire full = unread_count == 9'h100;
	wire ovw  = fifo_mode_select == 3'h6 || fifo_mode_select == 3'h3;
	wire push = sample_strobe && !fifo_pop;
	// stable input only: the register may lag the sensor by a cycle
	temp_read_a: assert property (
		!$past(rst) && reg_rd && reg_addr == 8'h26 && $stable(temp_code)
		|=> reg_rvalid && reg_rdata == $past(temp_code)) else $error("temperature read wrong");
	x_low_zero_a: assert property (
		reg_rd && reg_addr == 8'h28 |=> reg_rvalid && reg_rdata[1:0] == 2'b00)
		else $error("x low bits not zero");
	src_fields_a: assert property (
		reg_rd && reg_addr == 8'h2f
		|=> reg_rdata[5] == $past(unread_count[COUNT_WIDTH-1]) && reg_rdata[4:0] == 5'h00)
		else $error("fill status fields wrong");
	count_low_a: assert property (
		reg_rd && reg_addr == 8'h30 |=> reg_rdata == $past(unread_count[7:0]))
		else $error("count low byte wrong");
	count_bound_a: assert property (unread_count <= 9'h100) else $error("count above full");
	overrun_full_a: assert property (fifo_overrun_flag |-> full) else $error("overrun not full");
	overrun_set_a: assert property (
		push && full && ovw |=> fifo_overrun_flag && full) else $error("overwrite missed");
	push_count_a: assert property (
		push && !full && fifo_mode_select != 3'h0 |=> unread_count == $past(unread_count) + 9'h001)
		else $error("push not counted");
	bypass_clear_a: assert property (
		fifo_mode_select == 3'h0 |=> unread_count == 9'h000 && !fifo_overrun_flag)
		else $error("bypass not empty");
	full_pop_a: assert property (
		sample_strobe && fifo_pop && full && fifo_mode_select != 3'h0
		|=> full && !fifo_overrun_flag) else $error("push with pop at full wrong");
	full_c: cover property (full);
	overrun_c: cover property ($rose(fifo_overrun_flag));
	status_read_c: cover property (reg_rd && reg_addr == 8'h27);
endmodule // acc_regs_monitor

bind acc_output_status_regs acc_regs_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) i_acc_regs_monitor (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .temp_code(temp_code),
	.sample_strobe(sample_strobe), .fifo_mode_select(fifo_mode_select),
	.fifo_pop(fifo_pop), .fifo_overrun_flag(fifo_overrun_flag), .unread_count(unread_count));

// ===== acc_host_model.sv
// host side model issuing single register reads and writes
`timescale 1ns/1ps
module acc_host_model (
	input  wire       sys_clk,
	input  wire [7:0] reg_rdata,
	input  wire       reg_rvalid,
	output reg  [7:0] reg_addr,
	output reg        reg_wr,
	output reg        reg_rd,
	output reg  [7:0] reg_wdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// idle address inverted so a stale value never looks valid
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(negedge sys_clk);
			reg_addr = a;
			reg_rd = 1'b1;
			@(negedge sys_clk);
			reg_rd = 1'b0;
			reg_addr = ~a;
			d = reg_rvalid ? reg_rdata : 8'hxx;
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		begin
			@(negedge sys_clk);
			reg_addr = a;
			reg_wdata = v;
			reg_wr = 1'b1;
			@(negedge sys_clk);
			reg_wr = 1'b0;
			reg_addr = ~a;
			reg_wdata = ~v;
		end
	endtask
endmodule // acc_host_model

// ===== testbench.sv
// self-checking bench for the accelerometer output register bank
`timescale 1ns/1ps
module testbench;
	reg         sys_clk = 1'b0, rst = 1'b1, sample_strobe = 1'b0, fifo_pop = 1'b0;
	reg         high_rate_mode = 1'b0, low_power_mode = 1'b0;
	reg  [2:0]  fifo_mode_select = 3'h0;
	reg  [5:0]  ev = 6'h00;
	reg  [7:0]  temp_code = 8'h00, a, d;
	reg  [15:0] accel_x = 16'h0000, w, av;
	reg  [17:0] rows [0:3];
	wire [7:0]  reg_addr, reg_wdata, reg_rdata;
	wire        reg_wr, reg_rd, reg_rvalid, lvl;
	integer     i, fail_count = 0, checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	acc_host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
	acc_output_status_regs i_acc_output_status_regs (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.temp_code(temp_code), .sample_strobe(sample_strobe), .accel_x(accel_x),
		.accel_y(~accel_x), .accel_z(accel_x ^ 16'h5a5a), .high_rate_mode(high_rate_mode),
		.low_power_mode(low_power_mode), .wake_event(ev[5]), .sleep_event(ev[4]),
		.double_tap_event(ev[3]), .single_tap_event(ev[2]), .orientation_event(ev[1]),
		.free_fall_event(ev[0]), .fifo_mode_select(fifo_mode_select), .fifo_pop(fifo_pop),
		.fifo_level_reached_flag(lvl), .fifo_overrun_flag(), .unread_count());
	function [7:0] lowb(input [15:0] v, input hr, input lp);
		lowb = v[7:0] & 8'hfc & (hr ? 8'hf3 : 8'hff) & (lp ? 8'hc3 : 8'hff);
	endfunction
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t ns: read %h, wanted %h", $time, seen, exp);
			end
		end
	endtask
	task rc(input [7:0] ad, input [7:0] exp);
		begin
			host.rd(ad, d);
			chk(d, exp);
		end
	endtask
	// two cycles a sample keeps strobes one cycle wide
	task push(input integer n);
		repeat (n) begin
			@(negedge sys_clk);
			sample_strobe = 1'b1;
			@(negedge sys_clk);
			sample_strobe = 1'b0;
		end
	endtask
	task end_sim;
		begin
			if (fail_count == 0 && checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		#100000;
		fail_count = fail_count + 1;
		end_sim;
	end
	initial begin
		rows[0] = {2'b00, 16'h12ff};
		rows[1] = {2'b10, 16'h80ff};
		rows[2] = {2'b01, 16'hffff};
		rows[3] = {2'b11, 16'h7f3d};
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		for (a = 8'h26; a < 8'h31; a = a + 1) rc(a, 8'h00);
		rc(8'h3f, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			{high_rate_mode, low_power_mode, w} = rows[i];
			accel_x = w;
			push(1);
			accel_x = ~w;
			rc(8'h27, 8'h01);
			for (a = 0; a < 3; a = a + 1) begin
				av = (a == 0) ? w : (a == 1) ? ~w : w ^ 16'h5a5a;
				rc(8'h28 + {a[6:0], 1'b0}, lowb(av, high_rate_mode, low_power_mode));
				rc(8'h29 + {a[6:0], 1'b0}, av[15:8]);
			end
		end
		host.wr(8'h29, 8'h55);
		host.wr(8'h2f, 8'h55);
		rc(8'h29, w[15:8]);
		rc(8'h2f, 8'h00);
		temp_code = 8'he7;
		rc(8'h26, 8'he7);
		for (i = 0; i < 6; i = i + 1) begin
			@(negedge sys_clk);
			ev = 6'h01 << i;
			@(negedge sys_clk);
			ev = 6'h00;
			rc(8'h27, {1'b0, 6'h01 << i, 1'b0});
			rc(8'h27, 8'h00);
		end
		host.wr(8'h2e, 8'h03);
		rc(8'h2e, 8'h03);
		fifo_mode_select = 3'h6;
		push(2);
		rc(8'h2f, 8'h00);
		push(1);
		rc(8'h27, 8'h81);
		chk({7'h00, lvl}, 8'h01);
		rc(8'h30, 8'h03);
		push(253);
		rc(8'h2f, 8'ha0);
		push(1);
		rc(8'h2f, 8'he0);
		rc(8'h30, 8'h00);
		@(negedge sys_clk);
		fifo_pop = 1'b1;
		@(negedge sys_clk);
		fifo_pop = 1'b0;
		rc(8'h2f, 8'h80);
		rc(8'h30, 8'hff);
		fifo_mode_select = 3'h1;
		push(2);
		rc(8'h2f, 8'ha0);
		fifo_mode_select = 3'h0;
		rc(8'h2f, 8'h00);
		chk({7'h00, lvl}, 8'h00);
		// event in the very cycle of a status read must survive the clear
		fork
			host.rd(8'h27, d);
			begin
				@(negedge sys_clk);
				ev = 6'h20;
				@(negedge sys_clk);
				ev = 6'h00;
			end
		join
		chk(d, 8'h01);
		rc(8'h27, 8'h40);
		fifo_mode_select = 3'h6;
		push(257);
		rc(8'h2f, 8'he0);
		@(negedge sys_clk);
		sample_strobe = 1'b1;
		fifo_pop = 1'b1;
		@(negedge sys_clk);
		sample_strobe = 1'b0;
		fifo_pop = 1'b0;
		rc(8'h2f, 8'ha0);
		rc(8'h30, 8'h00);
		@(negedge sys_clk);
		rst = 1'b1;
		@(negedge sys_clk);
		rst = 1'b0;
		rc(8'h2e, 8'h00);
		rc(8'h28, 8'h00);
		rc(8'h2f, 8'h80);
		rc(8'h30, 8'h00);
		end_sim;
	end
endmodule // testbench
